// File: sfe_frame_end.sv
`timescale 1ns/100ps
// Behaviour
// [RULE1] Sixteen-bit character gap limit in ms, reset value 100 ms.
// [RULE2] Sixteen-bit response deadline in ms; zero disables; default 1000 ms.
// [RULE3] Deadline count restarts each time software sets the receive bit.
// [RULE4] Timeout status pulses for one cycle when the deadline expires.
// [RULE5] After a timeout, software must set receive again before frames count.
// [RULE6] First delimiter compared only in one- or two-delimiter modes.
// [RULE7] Second delimiter, default zero, used only in two-delimiter mode.
// [RULE8] Minimum ms gap between client requests; zero means no wait.
// [RULE9] Config byte n is server address; n+1 packs read/write counts.
// [RULE10] Bytes n+2, n+3 are function codes; n+4..n+5 read start.
// [RULE11] Bytes n+6 and n+7 hold the write start address.
// [RULE12] In gap mode, a gap beyond the limit ends the frame.
// [RULE13] Mode codes: 0 gap, 1 one delimiter, 2 two, 3 fixed length.
// [RULE14] In each start address the lower offset holds the high byte.
module sfe_frame_end #(
    parameter int MS_CYCLES = sfe_pkg::MS_CYCLES
) (
    input  wire logic              pclk,       // Module clock, 25 MHz
    input  wire logic              presetn,    // Async reset, active low
    input  wire logic              psel,       // APB select
    input  wire logic              penable,    // APB access phase
    input  wire logic              pwrite,     // APB write
    input  wire logic [7:0]        paddr,      // APB byte address
    input  wire logic [31:0]       pwdata,     // APB write data
    output logic [31:0]            prdata,     // APB read data
    output logic                   pready,     // APB ready
    output logic                   pslverr,    // APB error, unmapped
    input  wire sfe_pkg::sfe_char_s rx_char,   // Received character strobe
    input  wire logic              req_want,   // Client wants to send
    output logic                   req_go,     // Request may go now
    output logic                   frame_end,  // Frame complete pulse
    output logic                   timeout,    // Deadline expiry pulse
    output logic                   rx_active,  // Receive sequence running
    output sfe_pkg::sfe_scb_s      scb_cfg     // Decoded server config
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [15:0]      gap_lim;
        logic [15:0]      resp_lim;
        logic [7:0]       delim1;
        logic [7:0]       delim2;
        sfe_pkg::sfe_eof_e mode;
        logic [7:0]       flen;
        logic [15:0]      req_gap;
        logic [63:0]      scb;
        sfe_pkg::sfe_rx_e rx;
        logic [15:0]      resp_cnt;
        logic [15:0]      gap_cnt;
        logic [7:0]       len_cnt;
        logic [15:0]      req_cnt;
        logic             done_flag;
        logic             tmo_flag;
        logic             tmo_pulse;
        logic             end_pulse;
        logic [31:0]      prdata;
    } sfe_state_s;

    sfe_state_s r;
    sfe_state_s next_r;
    logic       ms_tick;
    logic       wr_acc;
    logic       rd_setup;
    logic       mapped;
    logic       start;
    logic       listening;
    logic       go_ok;
    logic       hit_d1;

    function automatic logic sfe_hit(input logic [7:0] a,
                                     input logic [7:0] off);
        sfe_hit = (a == off);
    endfunction

    sfe_ms_tick #(
        .CYCLES  (MS_CYCLES)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (ms_tick)
    );

    sfe_scb_decode u_scb (
        .scb (r.scb),
        .cfg (scb_cfg)
    );

    // ****************************************************************
    // APB decode
    // ****************************************************************
    always_comb begin
        mapped = sfe_hit(paddr, sfe_pkg::OFF_CTRL)
              || sfe_hit(paddr, sfe_pkg::OFF_STATUS)
              || sfe_hit(paddr, sfe_pkg::OFF_GAP)
              || sfe_hit(paddr, sfe_pkg::OFF_RESP)
              || sfe_hit(paddr, sfe_pkg::OFF_FRAME)
              || sfe_hit(paddr, sfe_pkg::OFF_REQGAP)
              || sfe_hit(paddr, sfe_pkg::OFF_SCB0)
              || sfe_hit(paddr, sfe_pkg::OFF_SCB1);
    end

    // Zero wait states: read data is latched in the setup cycle
    assign pready   = 1'b1;
    assign pslverr  = psel && penable && !mapped;
    assign wr_acc   = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign start    = wr_acc && sfe_hit(paddr, sfe_pkg::OFF_CTRL)
                   && pwdata[sfe_pkg::CTRL_RECEIVE];
    // Characters outside a receive sequence are dropped
    assign listening = (r.rx != sfe_pkg::RX_IDLE);              // [RULE5]
    assign hit_d1    = (rx_char.data == r.delim1);
    assign go_ok     = (r.req_gap == 16'h0000)
                    || (r.req_cnt >= r.req_gap);                // [RULE8]
    assign req_go    = req_want && go_ok;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_r = r;
        next_r.tmo_pulse = 1'b0;
        next_r.end_pulse = 1'b0;

        // Register writes
        if (wr_acc) begin
            case (paddr)
                sfe_pkg::OFF_GAP:    next_r.gap_lim  = pwdata[15:0]; // [RULE1]
                sfe_pkg::OFF_RESP:   next_r.resp_lim = pwdata[15:0]; // [RULE2]
                sfe_pkg::OFF_FRAME: begin
                    next_r.delim1 = pwdata[sfe_pkg::FR_D1_LSB +: 8];  // [RULE6]
                    next_r.delim2 = pwdata[sfe_pkg::FR_D2_LSB +: 8];  // [RULE7]
                    next_r.mode   = sfe_pkg::sfe_eof_e'(
                        pwdata[sfe_pkg::FR_MODE_LSB +: 2]);           // [RULE13]
                    next_r.flen   = pwdata[sfe_pkg::FR_LEN_LSB +: 8];
                end
                sfe_pkg::OFF_REQGAP: next_r.req_gap  = pwdata[15:0]; // [RULE8]
                sfe_pkg::OFF_SCB0:   next_r.scb[31:0]  = pwdata;
                sfe_pkg::OFF_SCB1:   next_r.scb[63:32] = pwdata;
                sfe_pkg::OFF_STATUS: begin
                    if (pwdata[sfe_pkg::ST_DONE]) begin
                        next_r.done_flag = 1'b0;
                    end
                    if (pwdata[sfe_pkg::ST_TMO]) begin
                        next_r.tmo_flag = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // Request pacing counter saturates so long idle spells stay open
        if (req_go) begin
            next_r.req_cnt = 16'h0000;
        end else if (ms_tick && r.req_cnt != 16'hffff) begin
            next_r.req_cnt = r.req_cnt + 16'h0001;
        end

        // Receive sequence
        if (start) begin
            next_r.rx       = sfe_pkg::RX_WAIT;                 // [RULE3] [RULE5]
            next_r.resp_cnt = 16'h0000;                         // [RULE3]
            next_r.gap_cnt  = 16'h0000;
            next_r.len_cnt  = 8'h00;
        end else if (listening) begin
            if (ms_tick) begin
                next_r.resp_cnt = r.resp_cnt + 16'h0001;
                if (r.rx != sfe_pkg::RX_WAIT) begin
                    next_r.gap_cnt = r.gap_cnt + 16'h0001;
                end
            end
            if (rx_char.valid) begin
                next_r.gap_cnt = 16'h0000;
                next_r.len_cnt = r.len_cnt + 8'h01;
                next_r.rx      = sfe_pkg::RX_FRAME;
                case (r.mode)
                    sfe_pkg::EOF_DELIM1: begin
                        if (hit_d1) begin                       // [RULE6] [RULE13]
                            next_r.end_pulse = 1'b1;
                        end
                    end
                    sfe_pkg::EOF_DELIM2: begin
                        if (r.rx == sfe_pkg::RX_DELIM
                            && rx_char.data == r.delim2) begin  // [RULE7]
                            next_r.end_pulse = 1'b1;
                        end else if (hit_d1) begin              // [RULE6]
                            next_r.rx = sfe_pkg::RX_DELIM;
                        end
                    end
                    sfe_pkg::EOF_LENGTH: begin
                        if (r.len_cnt + 8'h01 == r.flen) begin  // [RULE13]
                            next_r.end_pulse = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end else if (r.mode == sfe_pkg::EOF_GAP
                         && r.rx != sfe_pkg::RX_WAIT && ms_tick
                         && r.gap_cnt + 16'h0001 >= r.gap_lim) begin
                next_r.end_pulse = 1'b1;                        // [RULE12]
            end
            // Frame end wins over an expiry in the same cycle
            if (!next_r.end_pulse && r.resp_lim != 16'h0000     // [RULE2]
                && ms_tick && r.resp_cnt + 16'h0001 >= r.resp_lim) begin
                next_r.tmo_pulse = 1'b1;                        // [RULE4]
            end
            if (next_r.end_pulse || next_r.tmo_pulse) begin
                next_r.rx = sfe_pkg::RX_IDLE;                   // [RULE5]
            end
        end

        // Hardware set beats a software clear in the same cycle
        if (next_r.end_pulse) begin
            next_r.done_flag = 1'b1;
        end
        if (next_r.tmo_pulse) begin
            next_r.tmo_flag = 1'b1;
        end

        // Read data
        if (rd_setup) begin
            next_r.prdata = 32'h0000_0000;
            case (paddr)
                sfe_pkg::OFF_STATUS: begin
                    next_r.prdata[sfe_pkg::ST_ACTIVE]  = listening;
                    next_r.prdata[sfe_pkg::ST_DONE]    = r.done_flag;
                    next_r.prdata[sfe_pkg::ST_TMO]     = r.tmo_flag;
                    next_r.prdata[sfe_pkg::ST_TMO_NOW] = r.tmo_pulse;
                    next_r.prdata[sfe_pkg::ST_STATE_LSB +: 2] = r.rx;
                end
                sfe_pkg::OFF_GAP:    next_r.prdata[15:0] = r.gap_lim;
                sfe_pkg::OFF_RESP:   next_r.prdata[15:0] = r.resp_lim;
                sfe_pkg::OFF_FRAME:
                    next_r.prdata = {r.flen, 6'h00, r.mode,
                                     r.delim2, r.delim1};
                sfe_pkg::OFF_REQGAP: next_r.prdata[15:0] = r.req_gap;
                sfe_pkg::OFF_SCB0:   next_r.prdata = r.scb[31:0];
                sfe_pkg::OFF_SCB1:   next_r.prdata = r.scb[63:32];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r          <= '0;
            r.gap_lim  <= sfe_pkg::RST_GAP_MS;                  // [RULE1]
            r.resp_lim <= sfe_pkg::RST_RESP_MS;                 // [RULE2]
            r.delim1   <= sfe_pkg::RST_DELIM1;
            r.delim2   <= sfe_pkg::RST_DELIM2;                  // [RULE7]
            r.mode     <= sfe_pkg::EOF_GAP;
            r.flen     <= sfe_pkg::RST_FRAME_LEN;
            r.req_gap  <= sfe_pkg::RST_REQGAP_MS;
            r.scb      <= sfe_pkg::RST_SCB;
            r.rx       <= sfe_pkg::RX_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign prdata    = r.prdata;
    assign frame_end = r.end_pulse;
    assign timeout   = r.tmo_pulse;
    assign rx_active = listening;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_gap_write;
        wr_acc && paddr == sfe_pkg::OFF_GAP |=>
            r.gap_lim == $past(pwdata[15:0]);
    endproperty
    a_gap_write: assert property (p_gap_write) // [RULE1]
        else $error("gap limit not written");

    property p_no_tmo_disabled;
        timeout |-> $past(r.resp_lim) != 16'h0000;
    endproperty
    a_no_tmo_disabled: assert property (p_no_tmo_disabled) // [RULE2]
        else $error("timeout with deadline disabled");

    property p_start;
        start |=> r.rx == sfe_pkg::RX_WAIT && r.resp_cnt == 16'h0000;
    endproperty
    a_start: assert property (p_start) // [RULE3]
        else $error("receive start did not restart deadline");

    property p_tmo_one;
        timeout |=> !timeout && !rx_active;
    endproperty
    a_tmo_one: assert property (p_tmo_one) // [RULE4]
        else $error("timeout pulse too long");

    property p_d1_end;
        listening && !start && rx_char.valid && hit_d1
            && r.mode == sfe_pkg::EOF_DELIM1 |=> frame_end;
    endproperty
    a_d1_end: assert property (p_d1_end) // [RULE6]
        else $error("first delimiter did not end frame");

    property p_d2_end;
        frame_end && r.mode == sfe_pkg::EOF_DELIM2 |->
            $past(rx_char.data) == r.delim2
            && $past(r.rx) == sfe_pkg::RX_DELIM;
    endproperty
    a_d2_end: assert property (p_d2_end) // [RULE7]
        else $error("two-delimiter end without second delimiter");

    property p_req_gap;
        req_go |-> r.req_gap == 16'h0000 || r.req_cnt >= r.req_gap;
    endproperty
    a_req_gap: assert property (p_req_gap) // [RULE8]
        else $error("request issued inside minimum gap");

    property p_gap_end;
        frame_end && r.mode == sfe_pkg::EOF_GAP |->
            $past(ms_tick) && !$past(rx_char.valid);
    endproperty
    a_gap_end: assert property (p_gap_end) // [RULE12]
        else $error("gap end not on a silent millisecond");

    property p_len_end;
        frame_end && r.mode == sfe_pkg::EOF_LENGTH |->
            r.len_cnt == r.flen;
    endproperty
    a_len_end: assert property (p_len_end) // [RULE13]
        else $error("length end at wrong character count");

    property p_idle_end;
        !listening && !start |=> !frame_end && !timeout;
    endproperty
    a_idle_end: assert property (p_idle_end) // [RULE5]
        else $error("event while receive idle");

    c_timeout:   cover property (timeout);
    c_d2_frame:  cover property (frame_end && r.mode == sfe_pkg::EOF_DELIM2);
    c_gap_frame: cover property (frame_end && r.mode == sfe_pkg::EOF_GAP);
    c_req:       cover property (req_go && r.req_gap != 16'h0000);
endmodule

// File: sfe_pkg.sv
package sfe_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS         = 1000000;
    localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_GAP    = 8'h08;
    localparam logic [7:0] OFF_RESP   = 8'h0c;
    localparam logic [7:0] OFF_FRAME  = 8'h10;
    localparam logic [7:0] OFF_REQGAP = 8'h14;
    localparam logic [7:0] OFF_SCB0   = 8'h18;
    localparam logic [7:0] OFF_SCB1   = 8'h1c;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTRL_RECEIVE   = 0;
    localparam int ST_ACTIVE      = 0;
    localparam int ST_DONE        = 1;
    localparam int ST_TMO         = 2;
    localparam int ST_TMO_NOW     = 3;
    localparam int ST_STATE_LSB   = 4;
    localparam int FR_D1_LSB      = 0;
    localparam int FR_D2_LSB      = 8;
    localparam int FR_MODE_LSB    = 16;
    localparam int FR_LEN_LSB     = 24;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [15:0] RST_GAP_MS    = 16'h0064;
    localparam logic [15:0] RST_RESP_MS   = 16'h03e8;
    localparam logic [7:0]  RST_DELIM1    = 8'h03;
    localparam logic [7:0]  RST_DELIM2    = 8'h00;
    localparam logic [7:0]  RST_FRAME_LEN = 8'h00;
    localparam logic [15:0] RST_REQGAP_MS = 16'h0000;
    localparam logic [63:0] RST_SCB       = 64'h0000_0000_0000_0001;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        EOF_GAP    = 2'b00,
        EOF_DELIM1 = 2'b01,
        EOF_DELIM2 = 2'b10,
        EOF_LENGTH = 2'b11
    } sfe_eof_e;

    typedef enum logic [1:0] {
        RX_IDLE  = 2'b00,
        RX_WAIT  = 2'b01,
        RX_FRAME = 2'b10,
        RX_DELIM = 2'b11
    } sfe_rx_e;

    typedef struct packed {
        logic [7:0]  server_addr;
        logic [3:0]  rd_count;
        logic [3:0]  wr_count;
        logic [7:0]  rd_func;
        logic [7:0]  wr_func;
        logic [15:0] rd_start;
        logic [15:0] wr_start;
    } sfe_scb_s;

    typedef struct packed {
        logic        valid;
        logic [7:0]  data;
    } sfe_char_s;

endpackage

// File: sfe_ms_tick.sv
`timescale 1ns/100ps
module sfe_ms_tick #(
    parameter int CYCLES = sfe_pkg::MS_CYCLES
) (
    input  wire logic pclk,     // Module clock
    input  wire logic presetn,  // Async reset, active low
    output logic      tick      // One-cycle pulse each millisecond
);
    localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } sfe_tick_s;

    sfe_tick_s r;
    sfe_tick_s next_r;

    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (r.cnt == W'(CYCLES - 1)) begin
            next_r.cnt  = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tick = r.tick;
endmodule

// File: sfe_scb_decode.sv
`timescale 1ns/100ps
module sfe_scb_decode (
    input  wire logic [63:0]     scb,  // Byte n at bits 7:0, n+7 at 63:56
    output sfe_pkg::sfe_scb_s    cfg   // Decoded server fields
);
    logic [7:0] cnt_byte;

    function automatic logic [7:0] sfe_byte(input logic [63:0] b,
                                            input int k);
        sfe_byte = b[8*k +: 8];
    endfunction

    always_comb begin
        cnt_byte        = sfe_byte(scb, 1);
        cfg.server_addr = sfe_byte(scb, 0);                    // [RULE9]
        cfg.rd_count    = cnt_byte[7:4];                       // [RULE9]
        cfg.wr_count    = cnt_byte[3:0];                       // [RULE9]
        cfg.rd_func     = sfe_byte(scb, 2);                    // [RULE10]
        cfg.wr_func     = sfe_byte(scb, 3);                    // [RULE10]
        // Lower offset holds the high byte
        cfg.rd_start = {sfe_byte(scb, 4),                      // [RULE14]
                        sfe_byte(scb, 5)};                     // [RULE10]
        cfg.wr_start = {sfe_byte(scb, 6),                      // [RULE14]
                        sfe_byte(scb, 7)};                     // [RULE11]
    end
endmodule

// File: sfe_server_model.sv
`timescale 1ns/100ps
// ****************************************************************
// Server reply stream: one character strobe per byte
// ****************************************************************
module sfe_server_model (
    input  wire logic          pclk,     // Module clock
    output sfe_pkg::sfe_char_s rx_char   // Character strobe to the port
);
    initial begin
        rx_char = 9'h000;
    end

    // Idle data is the inverse of the last byte, so nothing stale matches
    task automatic send(input logic [7:0] b, input int gap);
        @(posedge pclk);
        rx_char <= {1'b1, b};
        @(posedge pclk);
        rx_char <= {1'b0, ~b};
        repeat (gap) @(posedge pclk);
    endtask
endmodule

// File: tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam int MS = 4;
    logic               pclk, presetn, psel, penable, pwrite;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd, seed, s0;
    logic               pready, pslverr, er, req_want, req_go;
    logic               frame_end, timeout, rx_active;
    logic [7:0]         d1, d2;
    sfe_pkg::sfe_char_s rx_char;
    sfe_pkg::sfe_scb_s  scb_cfg;
    int                 bad_count, check_count, cyc, fe_cnt, to_cnt;
    int                 fe_at, to_at, st_cyc, c0, fe0, to0, n, last, minsp;

    sfe_frame_end #(.MS_CYCLES(MS)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_char(rx_char),
        .req_want(req_want), .req_go(req_go), .frame_end(frame_end),
        .timeout(timeout), .rx_active(rx_active), .scb_cfg(scb_cfg));
    sfe_server_model srv (.pclk(pclk), .rx_char(rx_char));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction
    function automatic sfe_pkg::sfe_scb_s exp_scb(input logic [31:0] a,
                                                  input logic [31:0] b);
        return {a[7:0], a[15:12], a[11:8], a[23:16], a[31:24],
                b[7:0], b[15:8], b[23:16], b[31:24]};
    endfunction
    function automatic logic in_rng(input int v, input int lo, input int hi);
        return (v >= lo) && (v <= hi);
    endfunction
    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic start_rx();
        wr(sfe_pkg::OFF_CTRL, 32'h1);
        st_cyc = cyc;
    endtask
    task automatic set_frame(input logic [7:0] len, input sfe_pkg::sfe_eof_e m);
        wr(sfe_pkg::OFF_FRAME, {len, 6'h00, m, d2, d1});
    endtask
    task automatic end_sim();
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (frame_end === 1'b1) begin fe_cnt++; fe_at = cyc; end
        if (timeout === 1'b1) begin to_cnt++; to_at = cyc; end
    end
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Run needs about 375 cycles; over fifty times that means a hang
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        end_sim();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata, req_want} = '0;
        presetn = 1'b0;
        seed = 32'h85df;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("gap_rst", sfe_pkg::OFF_GAP, {16'h0, sfe_pkg::RST_GAP_MS});
        rdchk("resp_rst", sfe_pkg::OFF_RESP, 32'h3e8);
        rdchk("frame_rst", sfe_pkg::OFF_FRAME, {sfe_pkg::RST_FRAME_LEN, 8'h00,
              sfe_pkg::RST_DELIM2, sfe_pkg::RST_DELIM1});
        rdchk("reqgap_rst", sfe_pkg::OFF_REQGAP, 32'h0);
        chk("scb_rst", exp_scb(32'h1, 32'h0), scb_cfg);
        rdchk("unmapped", 8'h20, 32'h0);
        chk("slverr", 1'b1, er);
        for (int i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            s0 = (i == 0) ? 32'hffffffff : seed;
            wr(sfe_pkg::OFF_GAP, s0);
            rdchk("gap_rw", sfe_pkg::OFF_GAP, {16'h0, s0[15:0]});
            wr(sfe_pkg::OFF_RESP, {s0[15:0], s0[31:16]});
            rdchk("resp_rw", sfe_pkg::OFF_RESP, {16'h0, s0[31:16]});
            wr(sfe_pkg::OFF_SCB0, s0);
            seed = lfsr(seed);
            wr(sfe_pkg::OFF_SCB1, seed);
            // The write lands at the access edge; look once it has settled
            @(posedge pclk);
            chk("scb", exp_scb(s0, seed), scb_cfg);
        end
        wr(sfe_pkg::OFF_RESP, 32'h0);
        d1 = seed[7:0];
        d2 = d1 ^ 8'h80;
        set_frame(8'h00, sfe_pkg::EOF_DELIM1);
        start_rx();
        fe0 = fe_cnt;
        srv.send(d1 ^ 8'h01, 0);
        srv.send(d2, 2);
        chk("d1_early", 0, fe_cnt - fe0);
        srv.send(d1, 2);
        chk("d1_end", 1, fe_cnt - fe0);
        chk("d1_idle", 1'b0, rx_active);
        set_frame(8'h00, sfe_pkg::EOF_DELIM2);
        start_rx();
        fe0 = fe_cnt;
        srv.send(d1, 0);
        srv.send(d1 ^ 8'h01, 0);
        srv.send(d2, 2);
        chk("d2_broken", 0, fe_cnt - fe0);
        srv.send(d1, 0);
        srv.send(d2, 2);
        chk("d2_end", 1, fe_cnt - fe0);
        set_frame(8'h03, sfe_pkg::EOF_LENGTH);
        start_rx();
        fe0 = fe_cnt;
        srv.send(d1, 0);
        srv.send(d2, 2);
        chk("len_early", 0, fe_cnt - fe0);
        srv.send(8'h11, 2);
        chk("len_end", 1, fe_cnt - fe0);
        wr(sfe_pkg::OFF_GAP, 32'h2);
        set_frame(8'h00, sfe_pkg::EOF_GAP);
        start_rx();
        fe0 = fe_cnt;
        srv.send(d1, 0);
        c0 = cyc;
        repeat (3 * MS + 4) @(posedge pclk);
        chk("gap_end", 1, fe_cnt - fe0);
        chk("gap_time", 1'b1, in_rng(fe_at - c0, MS, 2 * MS + 3));
        wr(sfe_pkg::OFF_RESP, 32'h3);
        set_frame(8'h00, sfe_pkg::EOF_DELIM1);
        start_rx();
        // Restart well before the first deadline could run out
        repeat (MS) @(posedge pclk);
        to0 = to_cnt;
        start_rx();
        repeat (5 * MS) @(posedge pclk);
        chk("to_pulse", 1, to_cnt - to0);
        chk("to_time", 1'b1, in_rng(to_at - st_cyc, 2 * MS, 3 * MS + 3));
        chk("to_idle", 1'b0, rx_active);
        rdchk("st_tmo", sfe_pkg::OFF_STATUS, 32'h6);
        wr(sfe_pkg::OFF_STATUS, 32'h6);
        rdchk("st_clr", sfe_pkg::OFF_STATUS, 32'h0);
        fe0 = fe_cnt;
        srv.send(d1, 2);
        chk("to_ignored", 0, fe_cnt - fe0);
        start_rx();
        srv.send(d1, 2);
        chk("to_restart", 1, fe_cnt - fe0);
        wr(sfe_pkg::OFF_RESP, 32'h0);
        start_rx();
        to0 = to_cnt;
        repeat (20 * MS) @(posedge pclk);
        chk("resp_off", 0, to_cnt - to0);
        srv.send(d1, 2);
        req_want <= 1'b1;
        n = 0;
        repeat (8) begin @(posedge pclk); n += (req_go === 1'b1); end
        chk("go_fast", 8, n);
        wr(sfe_pkg::OFF_REQGAP, 32'h2);
        {n, last, minsp} = {32'd0, -32'd1000, 32'd1000};
        for (int i = 0; i < 8 * MS; i++) begin
            @(posedge pclk);
            if (req_go === 1'b1) begin
                n++;
                if (i - last < minsp) minsp = i - last;
                last = i;
            end
        end
        chk("go_count", 1'b1, in_rng(n, 3, 5));
        chk("go_space", 1'b1, minsp > MS);
        req_want <= 1'b0;
        end_sim();
    end
endmodule
